// >>> input_rate_map.svh
// Purpose: offsets, fields, reset values and timing counts of the input rate generators
// Assumes: byte addresses on the local register port
// Notes:   definitions only
`ifndef INPUT_RATE_MAP_SVH
`define INPUT_RATE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SAMPLE_SETUP_OFFSET   8'h1c
`define TIMEBASE_OFFSET       8'h20

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define VCO_LSB               0
`define VCO_MSB               9
`define REF_LSB               12
`define REF_MSB               21
`define DIV_LSB               24
`define DIV_MSB               28
`define SAMPLE_SETUP_MASK     32'h1f3ff3ff
`define SAMPLE_SETUP_RESET    32'h0103f020
`define TIMEBASE_MSB          23
`define TIMEBASE_MASK         32'h00ffffff
`define TIMEBASE_RESET        32'h00002760

// ----------------------------------------------------------------
// rates and timing
// ----------------------------------------------------------------
`define FAST_PATH_DIVIDE      10'h010
`define SLOW_PATH_SHIFT       5
`define MASTER_CLK_KHZ        32'h00009d80
`define CLK_PERIOD_NS         10
`define TRIG_PULSE_NS         100
`define TRIG_PULSE_CYCLES     ((`TRIG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFFSET_FLIP           16'h8000

`endif

// >>> input_rate_pkg.sv
// Purpose: types shared by the input rate generators
// Assumes: nothing
// Notes:   constants live in input_rate_map.svh
package input_rate_pkg;

  typedef enum logic {
    PULSE_IDLE,
    PULSE_LOW
  } pulse_state_t;

endpackage

// >>> input_sample_rate_generators.sv
// Purpose: adc sample clock path, burst timebase, burst trigger and data coding
// Assumes: clk is the 40.320 MHz master clock; pins sampled through three flops
// Notes:   the pll itself is external; this block sets it up and divides its output
`timescale 1ns/1ps
`include "input_rate_map.svh"

module input_sample_rate_generators (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // local register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // board control bits
  input  wire logic        timebase_enable,
  input  wire logic        trigger_initiator,
  input  wire logic        offset_binary,
  input  wire logic        adc_clk_external,
  input  wire logic        sw_trigger,
  // pll setup and clock pins
  output logic      [9:0]  pll_vco_factor,
  output logic      [9:0]  pll_ref_factor,
  input  wire logic        pll_osc,
  input  wire logic        ext_adc_clk,
  output logic             adc_clk,
  output logic             sample_tick,
  output logic             high_rate_path,
  output logic      [31:0] master_clk_khz,
  // trigger pin and burst trigger
  input  wire logic        trig_i,
  output logic             trig_o,
  output logic             trig_oe,
  output logic             timebase_tick,
  output logic             burst_trigger,
  // sample data
  input  wire logic [15:0] adc_data_in,
  input  wire logic        adc_data_valid,
  output logic      [15:0] sample_data,
  output logic             sample_valid,
  input  wire logic [15:0] host_dac_data,
  input  wire logic        host_dac_valid,
  output logic      [15:0] dac_data,
  output logic             dac_valid
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] recode(input logic [15:0] d, input logic ob);
    recode = ob ? d : (d ^ `OFFSET_FLIP);
  endfunction

  function automatic logic [9:0] sample_period(input logic [4:0] div);
    sample_period = (div == 5'h00) ? `FAST_PATH_DIVIDE : {div, 5'h00};
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] sample_setup;
  logic [31:0] timebase_div;
  logic [31:0] next_sample_setup;
  logic [31:0] next_timebase_div;
  logic [31:0] next_reg_rdata;
  logic [4:0]  sample_div;

  assign sample_div = sample_setup[`DIV_MSB:`DIV_LSB];

  always_comb begin
    next_sample_setup = sample_setup;
    next_timebase_div = timebase_div;
    next_reg_rdata    = reg_rdata;
    if (reg_wr && reg_addr == `SAMPLE_SETUP_OFFSET) begin
      next_sample_setup = reg_wdata & `SAMPLE_SETUP_MASK;
    end else if (reg_wr && reg_addr == `TIMEBASE_OFFSET) begin
      next_timebase_div = reg_wdata & `TIMEBASE_MASK;
    end
    if (reg_rd) begin
      if (reg_addr == `SAMPLE_SETUP_OFFSET) begin
        next_reg_rdata = sample_setup;
      end else if (reg_addr == `TIMEBASE_OFFSET) begin
        next_reg_rdata = timebase_div;
      end else begin
        next_reg_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_setup <= `SAMPLE_SETUP_RESET;
      timebase_div <= `TIMEBASE_RESET;
      reg_rdata    <= 32'h00000000;
    end else begin
      sample_setup <= next_sample_setup;
      timebase_div <= next_timebase_div;
      reg_rdata    <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // pll setup outputs
  // ----------------------------------------------------------------
  // factors are passed unchecked; the range is software's to keep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_vco_factor <= 10'h020;
      pll_ref_factor <= 10'h03f;
      high_rate_path <= 1'b0;
      master_clk_khz <= 32'h00000000;
    end else begin
      pll_vco_factor <= sample_setup[`VCO_MSB:`VCO_LSB];
      pll_ref_factor <= sample_setup[`REF_MSB:`REF_LSB];
      high_rate_path <= (sample_div == 5'h00);
      master_clk_khz <= `MASTER_CLK_KHZ;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: osc, external clock, trigger
  // ----------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_stable;
  logic [2:0] pin_prev;
  logic [2:0] next_pin_stable;

  // a change counts only once the second and third stages agree
  always_comb begin
    next_pin_stable = ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_stable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1     <= 3'h1;
      pin_s2     <= 3'h1;
      pin_s3     <= 3'h1;
      pin_stable <= 3'h1;
      pin_prev   <= 3'h1;
    end else begin
      pin_s1     <= {pll_osc, ext_adc_clk, trig_i};
      pin_s2     <= pin_s1;
      pin_s3     <= pin_s2;
      pin_stable <= next_pin_stable;
      pin_prev   <= pin_stable;
    end
  end

  logic osc_rise;
  logic trig_fall;
  assign osc_rise  = pin_stable[2] & ~pin_prev[2];
  assign trig_fall = pin_prev[0] & ~pin_stable[0];

  // ----------------------------------------------------------------
  // adc clock and sample rate
  // ----------------------------------------------------------------
  // the osc must stay well below clk/6 to survive the sampling
  logic       adc_half;
  logic       adc_prev;
  logic [9:0] samp_cnt;
  logic       next_adc_half;
  logic       next_adc_clk;
  logic [9:0] next_samp_cnt;
  logic       next_sample_tick;
  logic       adc_rise;

  assign adc_rise = adc_clk & ~adc_prev;

  always_comb begin
    next_adc_half    = osc_rise ? ~adc_half : adc_half;
    next_adc_clk     = adc_clk_external ? pin_stable[1] : next_adc_half;
    next_samp_cnt    = samp_cnt;
    next_sample_tick = 1'b0;
    if (adc_rise) begin
      if (samp_cnt >= sample_period(sample_div) - 10'h001) begin
        next_samp_cnt    = 10'h000;
        next_sample_tick = 1'b1;
      end else begin
        next_samp_cnt = samp_cnt + 10'h001;
      end
    end
    // restart so a smaller divisor never leaves the count past its end
    if (reg_wr && reg_addr == `SAMPLE_SETUP_OFFSET) begin
      next_samp_cnt = 10'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_half    <= 1'b0;
      adc_clk     <= 1'b0;
      adc_prev    <= 1'b0;
      samp_cnt    <= 10'h000;
      sample_tick <= 1'b0;
    end else begin
      adc_half    <= next_adc_half;
      adc_clk     <= next_adc_clk;
      adc_prev    <= adc_clk;
      samp_cnt    <= next_samp_cnt;
      sample_tick <= next_sample_tick;
    end
  end

  // ----------------------------------------------------------------
  // burst timebase
  // ----------------------------------------------------------------
  // a divisor of zero gives no ticks at all
  logic [23:0] tb_cnt;
  logic [23:0] next_tb_cnt;
  logic        next_timebase_tick;
  logic [23:0] tb_div;

  assign tb_div = timebase_div[`TIMEBASE_MSB:0];

  always_comb begin
    next_tb_cnt        = 24'h000000;
    next_timebase_tick = 1'b0;
    if (timebase_enable && tb_div != 24'h000000) begin
      if (tb_cnt >= tb_div - 24'h000001) begin
        next_timebase_tick = 1'b1;
      end else begin
        next_tb_cnt = tb_cnt + 24'h000001;
      end
    end
    // restart on a new divisor so the first period is whole
    if (reg_wr && reg_addr == `TIMEBASE_OFFSET) begin
      next_tb_cnt = 24'h000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt        <= 24'h000000;
      timebase_tick <= 1'b0;
    end else begin
      tb_cnt        <= next_tb_cnt;
      timebase_tick <= next_timebase_tick;
    end
  end

  // ----------------------------------------------------------------
  // burst trigger and trigger pin
  // ----------------------------------------------------------------
  input_rate_pkg::pulse_state_t pulse_state;
  input_rate_pkg::pulse_state_t next_pulse_state;
  logic [7:0] pulse_cnt;
  logic [7:0] next_pulse_cnt;
  logic       next_burst_trigger;

  always_comb begin
    // the pin is our own output in initiator mode, so its edges are ignored
    next_burst_trigger = sw_trigger |
                         (trigger_initiator ? timebase_tick : trig_fall);
    next_pulse_state   = pulse_state;
    next_pulse_cnt     = pulse_cnt;
    case (pulse_state)
      input_rate_pkg::PULSE_IDLE: begin
        if (trigger_initiator && next_burst_trigger) begin
          next_pulse_state = input_rate_pkg::PULSE_LOW;
          next_pulse_cnt   = 8'(`TRIG_PULSE_CYCLES - 1);
        end
      end
      input_rate_pkg::PULSE_LOW: begin
        if (pulse_cnt == 8'h00) begin
          next_pulse_state = input_rate_pkg::PULSE_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt - 8'h01;
        end
      end
      default: begin
        next_pulse_state = input_rate_pkg::PULSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_state   <= input_rate_pkg::PULSE_IDLE;
      pulse_cnt     <= 8'h00;
      burst_trigger <= 1'b0;
      trig_o        <= 1'b1;
      trig_oe       <= 1'b0;
    end else begin
      pulse_state   <= next_pulse_state;
      pulse_cnt     <= next_pulse_cnt;
      burst_trigger <= next_burst_trigger;
      trig_o        <= (next_pulse_state != input_rate_pkg::PULSE_LOW);
      trig_oe       <= trigger_initiator;
    end
  end

  // ----------------------------------------------------------------
  // data coding
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_data  <= 16'h0000;
      sample_valid <= 1'b0;
      dac_data     <= 16'h0000;
      dac_valid    <= 1'b0;
    end else begin
      sample_data  <= recode(adc_data_in, offset_binary);
      sample_valid <= adc_data_valid;
      dac_data     <= recode(host_dac_data, offset_binary);
      dac_valid    <= host_dac_valid;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  setup_reserved_zero_a: assert property ((sample_setup & ~`SAMPLE_SETUP_MASK) == 32'h0)
    else $error("sample setup reserved bits set");
  timebase_upper_zero_a: assert property (
      reg_rd && reg_addr == `TIMEBASE_OFFSET |=> reg_rdata[31:24] == 8'h00)
    else $error("timebase upper bits not zero");
  timebase_disabled_a: assert property (!timebase_enable |=> !timebase_tick)
    else $error("timebase ticked while disabled");
  timebase_period_a: assert property (
      timebase_tick |-> $past(tb_cnt) == $past(tb_div) - 24'h000001)
    else $error("timebase tick at wrong count");
  target_ignores_a: assert property (
      !trigger_initiator && !sw_trigger && !trig_fall |=> !burst_trigger)
    else $error("target mode trigger without pin edge");
  initiator_trigger_a: assert property (
      trigger_initiator && timebase_tick |=> burst_trigger)
    else $error("timebase tick gave no burst trigger");
  pulse_width_a: assert property ($fell(trig_o) |-> (!trig_o && trig_oe) [*8])
    else $error("trigger pulse too short");
  coding_a: assert property (
      sample_data == recode($past(adc_data_in), $past(offset_binary)))
    else $error("sample coding wrong");
  half_rate_a: assert property (
      !$past(adc_clk_external) && !$past(adc_clk_external, 2) && $changed(adc_clk)
      |-> $past(osc_rise))
    else $error("internal adc clock changed without osc edge");
  sample_period_a: assert property (
      sample_tick |-> $past(samp_cnt) == sample_period($past(sample_div)) - 10'h001)
    else $error("sample tick at wrong count");
  high_rate_a: assert property (
      ##1 high_rate_path == ($past(sample_div) == 5'h00))
    else $error("high rate path flag wrong");

  tick_seen_c:     cover property (timebase_tick ##1 burst_trigger);
  target_edge_c:   cover property (!trigger_initiator && trig_fall ##1 burst_trigger);
  fast_sample_c:   cover property (high_rate_path && sample_tick);
  pulse_seen_c:    cover property ($fell(trig_o) ##[1:20] $rose(trig_o));

endmodule

// >>> input_sample_rate_generators_tb.sv
// Purpose: self-checking bench for the input rate generators
// Assumes: inputs change at the falling clk edge
// Notes:   trigger pin idles high through a pull-up
`timescale 1ns/1ps
`include "input_rate_map.svh"

module input_sample_rate_generators_tb;
  logic        clk, rst_n, reg_wr, reg_rd, timebase_enable, trigger_initiator;
  logic        offset_binary, adc_clk_external, sw_trigger, adc_data_valid, host_dac_valid;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, master_clk_khz;
  logic [15:0] adc_data_in, host_dac_data, sample_data, dac_data;
  logic [9:0]  pll_vco_factor, pll_ref_factor;
  logic        pll_osc, ext_adc_clk, adc_clk, sample_tick, high_rate_path, trig_i, trig_o;
  logic        trig_oe, timebase_tick, burst_trigger, sample_valid, dac_valid;
  logic        osc_run, fall_req, pin_en, pa;
  int          num_errors, num_checks, n_tb, n_bt, n_ar, n_st, n_lo;

  // pull-up wins when neither side drives
  assign trig_i = trig_oe ? trig_o : !pin_en;

  input_sample_rate_generators u_dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .timebase_enable, .trigger_initiator, .offset_binary, .adc_clk_external,
    .sw_trigger, .pll_vco_factor, .pll_ref_factor, .pll_osc, .ext_adc_clk, .adc_clk,
    .sample_tick, .high_rate_path, .master_clk_khz, .trig_i, .trig_o, .trig_oe,
    .timebase_tick, .burst_trigger, .adc_data_in, .adc_data_valid, .sample_data,
    .sample_valid, .host_dac_data, .host_dac_valid, .dac_data, .dac_valid);

  trigger_clock_partner u_partner (.clk, .osc_run, .fall_req, .pll_osc, .ext_adc_clk, .pin_en);

  always #5 clk = ~clk;

  // ----------------------------------------
  // event counters
  // ----------------------------------------
  always @(posedge clk) begin
    n_tb += timebase_tick;
    n_bt += burst_trigger;
    n_st += sample_tick;
    n_lo += (trig_o == 1'b0);
    n_ar += (adc_clk && !pa);
    pa = adc_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_st;
    int s;
    s = n_st;
    for (int i = 0; i < 3000 && n_st == s; i++) @(negedge clk);
  endtask

  // adc clock rises between two sample ticks, after two ticks to resync
  task automatic tick_span(input int exp);
    int s;
    wait_st;
    wait_st;
    s = n_ar;
    wait_st;
    chk(n_ar - s, exp);
  endtask

  task automatic rises(input int exp);
    int s;
    idle(40);
    s = n_ar;
    idle(320);
    chk(n_ar - s, exp);
  endtask

  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rd(`SAMPLE_SETUP_OFFSET, d);
    chk(d, 32'h0103f020);
    rd(`TIMEBASE_OFFSET, d);
    chk(d, 32'h00002760);
    chk({22'h0, pll_vco_factor}, 32'h00000020);
    chk({22'h0, pll_ref_factor}, 32'h0000003f);
    chk(master_clk_khz, 32'h00009d80);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    wr(`SAMPLE_SETUP_OFFSET, 32'hffffffff);
    rd(`SAMPLE_SETUP_OFFSET, d);
    chk(d, 32'h1f3ff3ff);
    chk({pll_vco_factor, pll_ref_factor}, {12'h0, 20'hfffff});
    wr(`TIMEBASE_OFFSET, 32'hffffffff);
    wr(8'h24, 32'h12345678);
    rd(`TIMEBASE_OFFSET, d);
    chk(d, 32'h00ffffff);
    rd(8'h24, d);
    chk(d, 32'h00000000);
  endtask

  task automatic t_coding;
    logic [15:0] v [4] = '{16'h0000, 16'h8000, 16'h1234, 16'hffff};
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        @(negedge clk);
        offset_binary = m[0];
        adc_data_in = v[i];
        host_dac_data = ~v[i];
        adc_data_valid = 1'b1;
        host_dac_valid = 1'b1;
        @(negedge clk);
        chk({sample_data, dac_data}, {v[i], ~v[i]} ^ (m ? 32'h0 : 32'h80008000));
        chk({sample_valid, dac_valid}, 32'h00000003);
      end
    end
    adc_data_valid = 1'b0;
    host_dac_valid = 1'b0;
    offset_binary = 1'b1;
  endtask

  task automatic t_timebase;
    wr(`TIMEBASE_OFFSET, 32'h00000005);
    timebase_enable = 1'b1;
    idle(10);
    n_tb = 0;
    idle(100);
    chk(n_tb, 20);
    wr(`TIMEBASE_OFFSET, 32'h00000001);
    idle(5);
    n_tb = 0;
    idle(50);
    chk(n_tb, 50);
    timebase_enable = 1'b0;
    idle(3);
    n_tb = 0;
    idle(50);
    chk(n_tb, 0);
  endtask

  task automatic t_trigger;
    wr(`TIMEBASE_OFFSET, 32'h00000014);
    trigger_initiator = 1'b1;
    timebase_enable = 1'b1;
    idle(30);
    n_bt = 0;
    n_lo = 0;
    idle(200);
    chk(n_bt, 10);
    chk(n_lo, 100);
    chk({31'h0, trig_oe}, 32'h00000001);
    trigger_initiator = 1'b0;
    idle(12);
    n_bt = 0;
    n_tb = 0;
    idle(200);
    chk(n_bt, 0);
    chk(n_tb, 10);
    fall_req = 1'b1;
    idle(2);
    fall_req = 1'b0;
    idle(20);
    chk(n_bt, 1);
    n_bt = 0;
    sw_trigger = 1'b1;
    idle(1);
    sw_trigger = 1'b0;
    idle(3);
    chk(n_bt, 1);
    timebase_enable = 1'b0;
  endtask

  task automatic t_adc;
    wr(`SAMPLE_SETUP_OFFSET, 32'h0003f020);
    idle(3);
    chk({31'h0, high_rate_path}, 32'h00000001);
    tick_span(16);
    wr(`SAMPLE_SETUP_OFFSET, 32'h0103f020);
    idle(3);
    chk({31'h0, high_rate_path}, 32'h00000000);
    tick_span(32);
    rises(10);
    adc_clk_external = 1'b1;
    rises(20);
    adc_clk_external = 1'b0;
  endtask

  initial begin
    {clk, rst_n, reg_wr, reg_rd, timebase_enable, trigger_initiator} = 6'h0;
    {adc_clk_external, sw_trigger, adc_data_valid, host_dac_valid, fall_req} = 5'h0;
    offset_binary = 1'b1;
    osc_run = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    adc_data_in = 16'h0;
    host_dac_data = 16'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_coding;
    t_timebase;
    t_trigger;
    t_adc;
    conclude;
  end

  // about five times the expected run
  initial begin
    #300us;
    num_errors++;
    conclude;
  end
endmodule

// >>> trigger_clock_partner.sv
// Purpose: far side of the rate generators: pll oscillator, external adc clock, trigger pin
// Assumes: outputs change after the rising clk edge, slower than clk/8
// Notes:   frequencies scaled to the sim clock
`timescale 1ns/1ps

module trigger_clock_partner (
  // clock
  input  wire logic clk,
  // commands from the bench
  input  wire logic osc_run,
  input  wire logic fall_req,
  // pins
  output logic      pll_osc,
  output logic      ext_adc_clk,
  output logic      pin_en
);
  logic [2:0] ph;
  logic [3:0] hold;
  logic       req_q;

  initial begin
    pll_osc = 1'b0;
    ext_adc_clk = 1'b0;
    pin_en = 1'b0;
    ph = 3'h0;
    hold = 4'h0;
    req_q = 1'b0;
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  always @(posedge clk) begin
    if (osc_run) begin
      ph <= ph + 3'h1;
    end
    // fixed rate whatever the factors: one toggle every eight clk cycles while osc_run
    if (osc_run && ph == 3'h0) begin
      pll_osc <= ~pll_osc;
    end
    // even high and low halves
    if (osc_run && ph == 3'h4) begin
      ext_adc_clk <= ~ext_adc_clk;
    end
    // one low pulse on the pin, then release to the pull-up
    req_q <= fall_req;
    if (fall_req && !req_q) begin
      hold <= 4'h6;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
    pin_en <= (hold != 4'h0);
  end
endmodule
